// file: hdl/comparator_threshold_control.v
// APB register bank for comparator channel D and the two threshold DAC codes.
//
// The APB slave port was left to the implementer.
`timescale 1ns/10ps
`include "comparator_threshold_control_defines.vh"
module comparator_threshold_control (
    pclk,
    presetn,
    psel,
    penable,
    pwrite,
    paddr,
    pwdata,
    pstrb,
    prdata,
    pready,
    pslverr,
    comparator_d_raw,
    threshold_level_first,
    threshold_level_second,
    dac_output_level,
    chan_d_enable,
    chan_d_threshold_source,
    chan_d_result,
    chan_d_settled,
    irq
);
    input wire pclk;
    input wire presetn;
    input wire psel;
    input wire penable;
    input wire pwrite;
    input wire [`ADDR_WIDTH-1:0] paddr;
    input wire [31:0] pwdata;
    input wire [3:0] pstrb;
    output reg [31:0] prdata;
    output wire pready;
    output reg pslverr;
    input wire comparator_d_raw;
    output reg [7:0] threshold_level_first;
    output reg [7:0] threshold_level_second;
    output reg [7:0] dac_output_level;
    output reg chan_d_enable;
    output reg chan_d_threshold_source;
    output reg chan_d_result;
    output reg chan_d_settled;
    output wire irq;

    // Settling count: a least time, so it rounds up to whole cycles.
    localparam integer SETTLE_CYCLES_FULL =
        (`SETTLE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
    localparam [9:0] SETTLE_CYCLES = SETTLE_CYCLES_FULL[9:0];

    // Settling counter states, one-hot.
    localparam [2:0] ST_OFF = 3'h1;
    localparam [2:0] ST_SETTLING = 3'h2;
    localparam [2:0] ST_READY = 3'h4;

    // Byte address of a register index.
    function [`ADDR_WIDTH-1:0] byte_addr;
        input [15:0] index;
        begin
            byte_addr = {index, 2'b00};
        end
    endfunction

    // True when the bus address selects the register at the given index.
    function hits;
        input [`ADDR_WIDTH-1:0] addr;
        input [15:0] index;
        begin
            hits = (addr == byte_addr(index));
        end
    endfunction

    reg chan_d_irq_enable;
    reg chan_d_output_invert;
    reg [`IRQ_WIDTH-1:0] irq_status;
    reg [`IRQ_WIDTH-1:0] irq_enable;
    reg [2:0] settle_state;
    reg [2:0] next_settle_state;
    reg [9:0] settle_count;
    reg [9:0] next_settle_count;
    reg [31:0] next_prdata;
    reg next_pslverr;
    reg chan_d_enable_seen;
    reg next_result;
    reg [`IRQ_WIDTH-1:0] irq_set;
    reg [`IRQ_WIDTH-1:0] irq_clear;

    wire sync_level;
    wire setup_phase;
    wire write_access;
    wire low_lane;
    wire mapped;
    wire [`CTRL_WIDTH-1:0] ctrl_word;

    // The comparator output arrives from the analog side, so it crosses into pclk here.
    level_sync u_level_sync (
        .pclk(pclk),
        .presetn(presetn),
        .async_in(comparator_d_raw),
        .level(sync_level),
        .changed()
    );

    // APB phase decode; the slave never inserts wait states.
    assign pready = 1'b1;
    assign setup_phase = psel && !penable;
    assign write_access = psel && penable && pwrite && pready;
    assign low_lane = pstrb[0];
    assign mapped = hits(paddr, `IDX_THRESHOLD_LEVEL_A) || hits(paddr, `IDX_THRESHOLD_LEVEL_B)
        || hits(paddr, `IDX_CHAN_D_CONTROL) || hits(paddr, `IDX_CHAN_D_STATE)
        || hits(paddr, `IDX_IRQ_STATUS) || hits(paddr, `IDX_IRQ_CLEAR)
        || hits(paddr, `IDX_IRQ_ENABLE);

    // Control word as software sees it.
    assign ctrl_word = {chan_d_output_invert, chan_d_irq_enable, chan_d_threshold_source,
        chan_d_enable};

    // Read data is captured in the setup cycle so prdata comes from a flip-flop.
    // Reserved bits and the write-only clear register read as zero.
    always @* begin
        next_prdata = prdata;
        next_pslverr = pslverr;
        if (setup_phase) begin
            next_prdata = 32'h0000_0000;
            next_pslverr = !mapped;
            if (!pwrite) begin
                if (hits(paddr, `IDX_THRESHOLD_LEVEL_A)) begin
                    next_prdata[7:0] = threshold_level_first;
                end
                if (hits(paddr, `IDX_THRESHOLD_LEVEL_B)) begin
                    next_prdata[7:0] = threshold_level_second;
                end
                if (hits(paddr, `IDX_CHAN_D_CONTROL)) begin
                    next_prdata[`CTRL_WIDTH-1:0] = ctrl_word;
                end
                if (hits(paddr, `IDX_CHAN_D_STATE)) begin
                    next_prdata[`BIT_STATE_RESULT] = chan_d_result;
                    next_prdata[`BIT_STATE_SETTLED] = chan_d_settled;
                end
                if (hits(paddr, `IDX_IRQ_STATUS)) begin
                    next_prdata[`IRQ_WIDTH-1:0] = irq_status;
                end
                if (hits(paddr, `IDX_IRQ_ENABLE)) begin
                    next_prdata[`IRQ_WIDTH-1:0] = irq_enable;
                end
            end
        end
    end

    // Bus answer registers.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            prdata <= next_prdata;
            pslverr <= next_pslverr;
        end
    end

    // Software-written registers take effect at the access-phase edge, low byte lane only.
    // Codes go to the DACs unchanged: zero gives zero volts, all ones gives full scale.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            threshold_level_first <= `RESET_THRESHOLD;
            threshold_level_second <= `RESET_THRESHOLD;
            chan_d_enable <= 1'b0;
            chan_d_threshold_source <= 1'b0;
            chan_d_irq_enable <= 1'b0;
            chan_d_output_invert <= 1'b0;
            irq_enable <= `RESET_IRQ;
        end else if (write_access && low_lane) begin
            if (hits(paddr, `IDX_THRESHOLD_LEVEL_A)) begin
                threshold_level_first <= pwdata[7:0];
            end
            if (hits(paddr, `IDX_THRESHOLD_LEVEL_B)) begin
                threshold_level_second <= pwdata[7:0];
            end
            if (hits(paddr, `IDX_CHAN_D_CONTROL)) begin
                chan_d_enable <= pwdata[`BIT_CHAN_D_ENABLE];
                chan_d_threshold_source <= pwdata[`BIT_CHAN_D_THRESHOLD_SOURCE];
                chan_d_irq_enable <= pwdata[`BIT_CHAN_D_IRQ_ENABLE];
                chan_d_output_invert <= pwdata[`BIT_CHAN_D_OUTPUT_INVERT];
            end
            if (hits(paddr, `IDX_IRQ_ENABLE)) begin
                irq_enable <= pwdata[`IRQ_WIDTH-1:0];
            end
        end
    end

    // The general DAC output follows the second threshold code one cycle later.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dac_output_level <= `RESET_THRESHOLD;
        end else begin
            dac_output_level <= threshold_level_second;
        end
    end

    // Channel result: forced low while disabled, inverted on request.
    always @* begin
        next_result = 1'b0;
        if (chan_d_enable) begin
            next_result = sync_level ^ chan_d_output_invert;
        end
    end

    // Result register and enable history for edge detection of the enable bit.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            chan_d_result <= 1'b0;
            chan_d_enable_seen <= 1'b0;
        end else begin
            chan_d_result <= next_result;
            chan_d_enable_seen <= chan_d_enable;
        end
    end

    // Settling timer: restarts on each rise of the enable and stops when it falls.
    // It only reports readiness; the result is not gated, software must still wait.
    always @* begin
        next_settle_state = settle_state;
        next_settle_count = settle_count;
        case (settle_state)
            ST_OFF: begin
                if (chan_d_enable && !chan_d_enable_seen) begin
                    next_settle_state = ST_SETTLING;
                    next_settle_count = SETTLE_CYCLES - 10'd1;
                end
            end
            ST_SETTLING: begin
                if (!chan_d_enable) begin
                    next_settle_state = ST_OFF;
                    next_settle_count = 10'd0;
                end else if (settle_count == 10'd0) begin
                    next_settle_state = ST_READY;
                end else begin
                    next_settle_count = settle_count - 10'd1;
                end
            end
            ST_READY: begin
                if (!chan_d_enable) begin
                    next_settle_state = ST_OFF;
                end
            end
            default: begin
                next_settle_state = ST_OFF;
                next_settle_count = 10'd0;
            end
        endcase
    end

    // Settling state registers.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            settle_state <= ST_OFF;
            settle_count <= 10'd0;
            chan_d_settled <= 1'b0;
        end else begin
            settle_state <= next_settle_state;
            settle_count <= next_settle_count;
            chan_d_settled <= (next_settle_state == ST_READY);
        end
    end

    // Interrupt events. A toggle of the channel result counts only while the channel and
    // its interrupt are enabled; software writing the clear register drops a bit, but an
    // event in the same cycle wins so nothing is lost.
    always @* begin
        irq_set = `RESET_IRQ;
        irq_clear = `RESET_IRQ;
        if (chan_d_enable && chan_d_irq_enable && (next_result != chan_d_result)) begin
            irq_set[`BIT_IRQ_TOGGLE] = 1'b1;
        end
        if ((next_settle_state == ST_READY) && (settle_state == ST_SETTLING)) begin
            irq_set[`BIT_IRQ_SETTLED] = 1'b1;
        end
        if (write_access && low_lane && hits(paddr, `IDX_IRQ_CLEAR)) begin
            irq_clear = pwdata[`IRQ_WIDTH-1:0];
        end
    end

    // Sticky status bits.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_status <= `RESET_IRQ;
        end else begin
            irq_status <= (irq_status & ~irq_clear) | irq_set;
        end
    end

    // Level interrupt while any enabled status bit is set.
    assign irq = |(irq_status & irq_enable);
endmodule // comparator_threshold_control

// file: hdl/comparator_threshold_control_defines.vh
// Register indices, field positions, reset values and timing for the comparator control block.
`ifndef COMPARATOR_THRESHOLD_CONTROL_DEFINES_VH
`define COMPARATOR_THRESHOLD_CONTROL_DEFINES_VH

// Register indices; the APB byte address of each register is four times its index.
`define IDX_THRESHOLD_LEVEL_A 16'ha03a
`define IDX_THRESHOLD_LEVEL_B 16'ha03b
`define IDX_CHAN_D_CONTROL 16'ha030
`define IDX_CHAN_D_STATE 16'ha031
`define IDX_IRQ_STATUS 16'ha032
`define IDX_IRQ_CLEAR 16'ha033
`define IDX_IRQ_ENABLE 16'ha034

// Width of the APB address that the block decodes.
`define ADDR_WIDTH 18

// Channel D control register fields.
`define BIT_CHAN_D_ENABLE 0
`define BIT_CHAN_D_THRESHOLD_SOURCE 1
`define BIT_CHAN_D_IRQ_ENABLE 2
`define BIT_CHAN_D_OUTPUT_INVERT 3
`define CTRL_WIDTH 4

// Channel D state register fields.
`define BIT_STATE_RESULT 0
`define BIT_STATE_SETTLED 1

// Interrupt status, clear and enable register fields.
`define BIT_IRQ_TOGGLE 0
`define BIT_IRQ_SETTLED 1
`define IRQ_WIDTH 2

// Reset values.
`define RESET_THRESHOLD 8'h00
`define RESET_CTRL 4'h0
`define RESET_IRQ 2'h0

// Timing: analog bias settling after the channel enable rises.
`define CLK_PERIOD_NS 40
`define SETTLE_TIME_NS 20000

`endif

// file: hdl/level_sync.v
// Three-stage synchroniser for an asynchronous level with agreement filter.
`timescale 1ns/10ps
module level_sync (
    pclk,
    presetn,
    async_in,
    level,
    changed
);
    input wire pclk;
    input wire presetn;
    input wire async_in;
    output reg level;
    output wire changed;

    reg stage1;
    reg stage2;
    reg stage3;

    // The first stage feeds only the second; the level moves once stages two and three agree.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stage1 <= 1'b0;
            stage2 <= 1'b0;
            stage3 <= 1'b0;
            level <= 1'b0;
        end else begin
            stage1 <= async_in;
            stage2 <= stage1;
            stage3 <= stage2;
            if (stage2 == stage3) begin
                level <= stage3;
            end
        end
    end

    // One-cycle pulse in the cycle the filtered level is about to change.
    assign changed = (stage2 == stage3) && (stage3 != level);
endmodule // level_sync

// file: testbench/comparator_threshold_control_monitor.sv
// Checker for the channel D control bits, threshold codes and interrupt gating.
`timescale 1ns/10ps
`include "comparator_threshold_control_defines.vh"
module comparator_threshold_control_checker (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`ADDR_WIDTH-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic comparator_d_raw,
    input wire logic [7:0] threshold_level_first,
    input wire logic [7:0] threshold_level_second,
    input wire logic [7:0] dac_output_level,
    input wire logic chan_d_enable,
    input wire logic chan_d_threshold_source,
    input wire logic chan_d_result,
    input wire logic chan_d_settled,
    input wire logic irq
);
    logic wr_hit;
    logic wr_ctl;
    logic [3:0] ctrl_seen;
    logic [1:0] ien_seen;
    // A write counts only when the low byte is strobed at a completed access.
    assign wr_hit = psel && penable && pwrite && pready && pstrb[0];
    assign wr_ctl = wr_hit && paddr == {`IDX_CHAN_D_CONTROL, 2'b00};
    // Shadow copies of the software settings, since the bit fields are not all on ports.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_seen <= 4'h0;
            ien_seen <= 2'h0;
        end else if (wr_ctl) begin
            ctrl_seen <= pwdata[3:0];
        end else if (wr_hit && paddr == {`IDX_IRQ_ENABLE, 2'b00}) begin
            ien_seen <= pwdata[1:0];
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_enable_follows: assert property (
        wr_ctl |=> chan_d_enable == $past(pwdata[0]))
        else $error("channel enable did not follow the control write");
    a_disabled_low: assert property (
        !chan_d_enable ##1 !chan_d_enable |-> !chan_d_result)
        else $error("result not low while channel disabled");
    a_source_follows: assert property (
        wr_ctl |=> chan_d_threshold_source == $past(pwdata[1]))
        else $error("threshold source did not follow the control write");
    a_irq_gated: assert property (
        $rose(irq) && !ien_seen[1] && $stable(ien_seen) |-> ctrl_seen[2] && ctrl_seen[0])
        else $error("interrupt raised without channel interrupt enable");
    a_output_sense: assert property (
        (chan_d_enable && $stable(comparator_d_raw) && $stable(ctrl_seen))[*8]
        |-> chan_d_result == (comparator_d_raw ^ ctrl_seen[3]))
        else $error("result sense does not match invert setting");
    a_first_code: assert property (
        wr_hit && paddr == {`IDX_THRESHOLD_LEVEL_A, 2'b00}
        |=> threshold_level_first == $past(pwdata[7:0]))
        else $error("first threshold code not applied");
    a_second_code: assert property (
        wr_hit && paddr == {`IDX_THRESHOLD_LEVEL_B, 2'b00}
        |=> threshold_level_second == $past(pwdata[7:0]))
        else $error("second threshold code not applied");
    a_dac_copy: assert property (
        wr_hit && paddr == {`IDX_THRESHOLD_LEVEL_B, 2'b00}
        |=> ##1 dac_output_level == $past(pwdata[7:0], 2))
        else $error("general output level does not follow second code");
endmodule // comparator_threshold_control_checker

// file: testbench/test_comparator_threshold_control.sv
// Self-checking bench for the comparator channel D and threshold register bank.
`timescale 1ns/10ps
`include "comparator_threshold_control_defines.vh"
module test_comparator_threshold_control;
    localparam logic [15:0] ia = `IDX_THRESHOLD_LEVEL_A;
    localparam logic [15:0] ib = `IDX_THRESHOLD_LEVEL_B;
    localparam logic [15:0] ictl = `IDX_CHAN_D_CONTROL;
    localparam logic [15:0] ist = `IDX_IRQ_STATUS;
    localparam logic [15:0] iclr = `IDX_IRQ_CLEAR;
    localparam logic [15:0] ien = `IDX_IRQ_ENABLE;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [`ADDR_WIDTH-1:0] paddr = '0;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'h0;
    logic raw = 1'b0;
    logic lane0 = 1'b1;
    wire [31:0] prdata;
    wire pready, pslverr, en, src, result, settled, irq;
    wire [7:0] lvl_first, lvl_second, dac_level;
    int num_errors = 0;
    int checked = 0;
    int cycles = 0;
    int mdl [int];
    logic [31:0] r;
    logic e;
    logic [7:0] v;
    logic [3:0] cv;

    comparator_threshold_control dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .comparator_d_raw(raw),
        .threshold_level_first(lvl_first), .threshold_level_second(lvl_second),
        .dac_output_level(dac_level), .chan_d_enable(en), .chan_d_threshold_source(src),
        .chan_d_result(result), .chan_d_settled(settled), .irq(irq));

    // Free-running 25 MHz clock.
    always #20 pclk = ~pclk;

    // Hang guard; the whole sequence needs under a thousand cycles.
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            num_errors++;
            finish_test();
        end
    end

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    // One APB transfer; ends one edge after release so outputs have settled.
    task apb(input logic wr, input logic [15:0] idx, input logic [7:0] wd,
             output logic [31:0] rd, output logic err);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= ($urandom & 32'hffffff00) | {24'h0, wd};
        pstrb <= {3'b111, lane0};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task wr(input logic [15:0] idx, input logic [7:0] wd);
        apb(1'b1, idx, wd, r, e);
        if (idx != iclr) mdl[idx] = wd;
    endtask

    task finish_test;
        $display("comparisons %0d, mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    initial begin
        void'($urandom(32'h7f5e));
        mdl[ia] = 0;
        mdl[ib] = 0;
        mdl[ictl] = 0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, ia, 8'h0, r, e); chk(r, mdl[ia]);
        apb(1'b0, ib, 8'h0, r, e); chk(r, mdl[ib]);
        apb(1'b0, ictl, 8'h0, r, e); chk(r, mdl[ictl]);
        // Extreme codes first, then random ones; second register gets the complement.
        for (int i = 0; i < 6; i++) begin
            v = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($urandom);
            wr(ia, v);
            wr(ib, ~v);
            apb(1'b0, ia, 8'h0, r, e); chk(r, mdl[ia]);
            chk(32'(lvl_first), 32'(v));
            apb(1'b0, ib, 8'h0, r, e); chk(r, mdl[ib]);
            chk(32'(dac_level), 32'(mdl[ib]));
        end
        // Every control setting against a random comparator level.
        for (int c = 0; c < 16; c++) begin
            cv = 4'(c);
            wr(ictl, {4'h0, cv});
            raw <= 1'($urandom);
            repeat (8) @(posedge pclk);
            chk(32'(en), 32'(cv[0]));
            chk(32'(src), 32'(cv[1]));
            chk(32'(result), 32'(cv[0] & (raw ^ cv[3])));
            chk(32'(irq), 32'h0);
        end
        // Toggle without the channel interrupt enable, then with it.
        wr(iclr, 8'h03);
        wr(ien, 8'h01);
        wr(ictl, 8'h01);
        raw <= ~raw;
        repeat (8) @(posedge pclk);
        chk(32'(irq), 32'h0);
        apb(1'b0, ist, 8'h0, r, e); chk(r & 32'h1, 32'h0);
        wr(ictl, 8'h05);
        raw <= ~raw;
        repeat (8) @(posedge pclk);
        chk(32'(irq), 32'h1);
        apb(1'b0, ist, 8'h0, r, e); chk(r & 32'h1, 32'h1);
        wr(ien, 8'h00);
        chk(32'(irq), 32'h0);
        wr(ien, 8'h01);
        chk(32'(irq), 32'h1);
        wr(iclr, 8'h01);
        chk(32'(irq), 32'h0);
        // Unmapped place answers with an error and reads zero.
        apb(1'b0, 16'ha020, 8'h0, r, e);
        chk({r[30:0], e}, 32'h1);
        chk(32'(pready), 32'h1);
        wr(ictl, 8'h00);
        repeat (2) @(posedge pclk);
        chk(32'(result), 32'h0);
        // A write with the low byte lane off must leave the code alone.
        lane0 = 1'b0;
        apb(1'b1, ia, 8'h5a, r, e);
        lane0 = 1'b1;
        chk(32'(lvl_first), 32'(mdl[ia]));
        // Re-enable and wait out the bias settling before trusting the result.
        wr(iclr, 8'h03);
        wr(ien, 8'h02);
        wr(ictl, 8'h01);
        repeat (`SETTLE_TIME_NS / `CLK_PERIOD_NS - 1) @(posedge pclk);
        chk(32'(settled), 32'h0);
        repeat (2) @(posedge pclk);
        chk(32'(settled), 32'h1);
        chk(32'(irq), 32'h1);
        chk(32'(result), 32'(raw));
        // Unused thresholds are parked at zero to save power.
        wr(ia, 8'h00);
        wr(ib, 8'h00);
        chk(32'(lvl_first), 32'h0);
        chk(32'(lvl_second), 32'h0);
        finish_test();
    end
endmodule // test_comparator_threshold_control

bind comparator_threshold_control comparator_threshold_control_checker chk_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .comparator_d_raw(comparator_d_raw),
    .threshold_level_first(threshold_level_first),
    .threshold_level_second(threshold_level_second), .dac_output_level(dac_output_level),
    .chan_d_enable(chan_d_enable), .chan_d_threshold_source(chan_d_threshold_source),
    .chan_d_result(chan_d_result), .chan_d_settled(chan_d_settled), .irq(irq));
